// >>> shared/eep_pkg.sv
// Constants, opcodes, status layout and state codes of the serial EEPROM
package eep_pkg;
    // ------------------------------------------------------------
    // Clock and write cycle timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_WRITE_US = 1000;
    localparam int WRITE_CYCLES_DFLT = T_WRITE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int MEM_DEPTH = 1024;
    localparam int ADDR_W = 10;
    localparam int PAGE_SIZE = 16;
    localparam int PW = 4;
    localparam logic [ADDR_W-1:0] PROT_QUARTER = 10'h300;
    localparam logic [ADDR_W-1:0] PROT_HALF = 10'h200;

    // ------------------------------------------------------------
    // Instruction opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_SET_WEN = 8'h06;
    localparam logic [7:0] OP_CLR_WEN = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;

    // ------------------------------------------------------------
    // Status register layout and reset values
    // ------------------------------------------------------------
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 3;
    localparam int ST_PROTECT_PIN_ENABLE_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Pin order {cs_n, sck, si, hold_n, wp_n}
    localparam logic [4:0] PIN_RST = 5'h13;

    typedef enum logic [2:0] {
        EEP_IDLE = 3'b000,
        EEP_CMD = 3'b001,
        EEP_ADDR = 3'b010,
        EEP_RD = 3'b011,
        EEP_WR = 3'b100,
        EEP_SRD = 3'b101,
        EEP_SWR = 3'b110,
        EEP_SKIP = 3'b111
    } eep_state_e;
endpackage

// >>> shared/eep_wr_if.sv
// Handshake between the core and the self-timed write cycle timer
`timescale 1ns/1ps
`default_nettype none
interface eep_wr_if;
    logic start;
    logic busy;
    logic done;
    modport timer (input start, output busy, output done);
    modport ctrl (output start, input busy, input done);
endinterface
`default_nettype wire

// >>> rtl/eep_sync.sv
// Two flip-flop synchroniser for the external pins
`timescale 1ns/1ps
`default_nettype none
module eep_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta[i] <= RST_VAL[i];
                q[i] <= RST_VAL[i];
            end else begin
                meta[i] <= d[i];
                q[i] <= meta[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/eep_wtimer.sv
// Self-timed write cycle counter
`timescale 1ns/1ps
`default_nettype none
module eep_wtimer #(
    parameter int CYCLES = 125000
) (
    input wire logic clk,
    input wire logic rst_n,
    eep_wr_if.timer wr
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt;

    if (CYCLES < 1) begin : g_chk
        $error("CYCLES must be at least one");
    end

    // Once started nothing but the count ends the cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            wr.busy <= 1'b0;
            wr.done <= 1'b0;
        end else begin
            wr.done <= 1'b0;
            if (wr.start && !wr.busy) begin
                wr.busy <= 1'b1;
                cnt <= CW'(CYCLES - 1);
            end else if (wr.busy) begin
                if (cnt == '0) begin
                    wr.busy <= 1'b0;
                    wr.done <= 1'b1;
                end else begin
                    cnt <= cnt - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/eep_core.sv
// Serial port, write protection and hold logic of the serial EEPROM
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Write enable latch is cleared by reset.
// RULE2: Nothing is written unless the write enable latch is set.
// RULE3: Completing an array or status write clears the latch.
// RULE4: Write cycle starts on chip select rising after a clean sequence.
// RULE5: Array access during a write cycle is ignored; the cycle continues.
// RULE6: After reset: deselected standby, latch clear, output released.
// RULE7: Protect pin low with protect enable set blocks status writes.
// RULE8: Hardware status protection leaves every other operation untouched.
// RULE9: Protect enable clear makes the protect pin irrelevant.
// RULE10: Protect pin changes after a cycle starts do not affect it.
// RULE11: Serial traffic is honoured only while chip select is low.
// RULE12: A running write finishes; standby follows once it ends.
// RULE13: Deselected device releases its serial output.
// RULE14: A sequence begins only after chip select is seen low.
// RULE15: Input sampled on clock rise, output changed after clock fall.
// RULE16: Hold low pauses without losing the partial sequence.
// RULE17: Hold falling with clock high pauses at the next clock fall.
// RULE18: Host keeps chip select low for the whole pause.
// RULE19: While paused, input, clock and output activity is ignored.
// RULE20: Resume only when hold rises while the clock is low.
// RULE21: Any hold fall releases the serial output at once.
// RULE22: Eight-bit opcodes for read, write, latch set/clear, status read/write.
// RULE23: Status readable anytime; bits busy, latch, block protect, protect enable.
// RULE24: Block protect bits select none, top quarter, top half or all.
// RULE25: Latch set only when chip select rises right after its eight bits.
// RULE26: Writes to protected targets are dropped with no write cycle.
module eep_core
    import eep_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic standby,
    output logic write_busy
);
    if (ADDR_W <= 8 || ADDR_W > 16 || (1 << PW) != PAGE_SIZE) begin : g_chk
        $error("Unsupported address or page geometry");
    end

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_ff;
    logic rst_n;
    logic [4:0] pin_s;
    logic cs_n_s, sck_s, si_s, hold_n_s, wp_n_s;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];
    eep_sync #(.W(5), .RST_VAL(PIN_RST)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({cs_n, sck, si, hold_n, wp_n}),
        .q(pin_s)
    );
    assign {cs_n_s, sck_s, si_s, hold_n_s, wp_n_s} = pin_s;
    eep_wr_if wr ();
    eep_wtimer #(.CYCLES(WRITE_CYCLES)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .wr(wr)
    );

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sck_prev, hold_prev, cs_prev;
    logic sck_rise, sck_fall, hold_fall, hold_rise, cs_rise, selected;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev <= 1'b0;
            hold_prev <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            sck_prev <= sck_s;
            hold_prev <= hold_n_s;
            cs_prev <= cs_n_s;
        end
    end
    assign sck_rise = sck_s & ~sck_prev;
    assign sck_fall = ~sck_s & sck_prev;
    assign hold_fall = ~hold_n_s & hold_prev;
    assign hold_rise = hold_n_s & ~hold_prev;
    assign cs_rise = cs_n_s & ~cs_prev;
    assign selected = ~cs_n_s; // see RULE11

    // ------------------------------------------------------------
    // Hold pause
    // ------------------------------------------------------------
    logic paused, pause_pend, enter_pause;
    // Hold fall with clock high waits for the clock fall
    assign enter_pause = (hold_fall & ~sck_s)
        | (pause_pend & sck_fall & ~hold_n_s); // see RULE17
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            paused <= 1'b0;
            pause_pend <= 1'b0;
        end else if (!selected) begin
            paused <= 1'b0;
            pause_pend <= 1'b0;
        end else if (paused) begin
            paused <= ~(hold_rise & ~sck_s); // see RULE20
        end else if (enter_pause) begin
            paused <= 1'b1; // see RULE16
            pause_pend <= 1'b0;
        end else if (hold_fall) begin
            pause_pend <= 1'b1;
        end else if (hold_n_s) begin
            pause_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    eep_state_e state, cmd_state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg, op_q, tx, rx_byte, status_now, pend_st;
    logic [ADDR_W-1:0] addr, addr_next;
    logic [ADDR_W-PW-1:0] wr_page;
    logic [PW-1:0] page_off;
    logic [1:0] byte_cnt;
    logic addr_phase, over, tx_on, so_q, kind_st;
    logic write_enable_latch_bit, bp_hi, bp_lo, protect_pin_enable_bit;
    logic act, act_rise, act_fall, byte_done, seq_clean;
    logic prot_hit, hw_prot, start_arr, start_st, wen_end;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] page_buf [PAGE_SIZE];
    logic [PAGE_SIZE-1:0] mask;
    assign act = selected & ~paused; // see RULE19
    assign act_rise = sck_rise & act;
    assign act_fall = sck_fall & act;
    assign byte_done = act_rise & (bit_cnt == 3'h7);
    assign rx_byte = {shreg[6:0], si_s}; // see RULE15
    assign addr_next = {addr[ADDR_W-9:0], rx_byte};
    assign page_off = addr[PW-1:0];
    assign seq_clean = (bit_cnt == 3'h0);
    assign status_now = {protect_pin_enable_bit, 3'h0, bp_hi, bp_lo, write_enable_latch_bit, wr.busy}; // see RULE23
    assign prot_hit = ({bp_hi, bp_lo} == 2'h1 && addr >= PROT_QUARTER)
        | ({bp_hi, bp_lo} == 2'h2 && addr >= PROT_HALF)
        | ({bp_hi, bp_lo} == 2'h3); // see RULE24
    assign hw_prot = protect_pin_enable_bit & ~wp_n_s; // see RULE7, see RULE9
    // Dropped writes never reach the timer
    assign start_arr = cs_rise && state == EEP_WR && byte_cnt != 2'h0
        && seq_clean && write_enable_latch_bit && !prot_hit && !wr.busy; // see RULE26
    assign start_st = cs_rise && state == EEP_SWR && byte_cnt == 2'h1
        && seq_clean && write_enable_latch_bit && !hw_prot && !wr.busy; // see RULE2
    assign wr.start = start_arr | start_st; // see RULE4
    assign wen_end = cs_rise && state == EEP_SKIP && !over && seq_clean;
    // Array opcodes are refused while the timer runs
    assign cmd_state = (rx_byte == OP_READ || rx_byte == OP_WRITE)
        ? (wr.busy ? EEP_SKIP : EEP_ADDR) // see RULE5
        : (rx_byte == OP_RD_STATUS) ? EEP_SRD
        : (rx_byte == OP_WR_STATUS && !wr.busy) ? EEP_SWR
        : EEP_SKIP; // see RULE22

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= EEP_IDLE; // see RULE6
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            op_q <= 8'h00;
            addr <= '0;
            addr_phase <= 1'b0;
            byte_cnt <= 2'h0;
            over <= 1'b0;
            tx <= 8'h00;
            tx_on <= 1'b0;
            so_q <= 1'b0;
            pend_st <= STATUS_RESET;
        end else if (!selected) begin
            state <= EEP_IDLE;
            tx_on <= 1'b0;
        end else if (state == EEP_IDLE) begin
            state <= EEP_CMD; // see RULE14
            bit_cnt <= 3'h0;
            over <= 1'b0;
        end else begin
            if (act_rise) begin
                shreg <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
                over <= over | (state == EEP_SKIP);
            end
            if (byte_done) begin
                case (state)
                    EEP_CMD: begin
                        state <= cmd_state;
                        op_q <= rx_byte;
                        addr_phase <= 1'b0;
                        byte_cnt <= 2'h0;
                        if (cmd_state == EEP_SRD) begin
                            tx <= status_now;
                            tx_on <= 1'b1;
                        end
                    end
                    EEP_ADDR: begin
                        addr <= addr_next;
                        addr_phase <= 1'b1;
                        if (addr_phase && op_q == OP_READ) begin
                            state <= EEP_RD;
                            tx <= mem[addr_next];
                            tx_on <= 1'b1;
                        end else if (addr_phase) begin
                            state <= EEP_WR;
                        end
                    end
                    EEP_RD: begin
                        addr <= ADDR_W'(addr + 1'b1);
                        tx <= mem[ADDR_W'(addr + 1'b1)];
                    end
                    EEP_WR: begin
                        // Page wrap: only the low bits advance
                        addr <= {addr[ADDR_W-1:PW], PW'(page_off + 1'b1)};
                        byte_cnt <= (byte_cnt == 2'h2) ? 2'h2 : byte_cnt + 2'h1;
                    end
                    EEP_SRD: begin
                        tx <= status_now;
                    end
                    EEP_SWR: begin
                        pend_st <= rx_byte;
                        byte_cnt <= (byte_cnt == 2'h2) ? 2'h2 : byte_cnt + 2'h1;
                    end
                    default: begin
                    end
                endcase
            end
            if (act_fall && tx_on) begin
                so_q <= tx[7]; // see RULE15
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Page buffer and array commit
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (byte_done && state == EEP_CMD && rx_byte == OP_WRITE
                     && !wr.busy) begin
            mask <= '0;
        end else if (byte_done && state == EEP_WR) begin
            mask[page_off] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (byte_done && state == EEP_WR) begin
            page_buf[page_off] <= rx_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (wr.done && !kind_st) begin
            for (int i = 0; i < PAGE_SIZE; i++) begin
                if (mask[i]) begin
                    mem[{wr_page, PW'(i)}] <= page_buf[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status bits and write enable latch
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch_bit <= 1'b0; // see RULE1
            bp_hi <= STATUS_RESET[ST_BP_HI];
            bp_lo <= STATUS_RESET[ST_BP_LO];
            protect_pin_enable_bit <= STATUS_RESET[ST_PROTECT_PIN_ENABLE_BIT];
            kind_st <= 1'b0;
            wr_page <= '0;
        end else begin
            if (wr.done) begin
                write_enable_latch_bit <= 1'b0; // see RULE3
                if (kind_st) begin
                    protect_pin_enable_bit <= pend_st[ST_PROTECT_PIN_ENABLE_BIT];
                    bp_hi <= pend_st[ST_BP_HI];
                    bp_lo <= pend_st[ST_BP_LO];
                end
            end
            // Latch commands work even under hardware protection
            if (wen_end && op_q == OP_SET_WEN) begin
                write_enable_latch_bit <= 1'b1; // see RULE25, see RULE8
            end else if (wen_end && op_q == OP_CLR_WEN) begin
                write_enable_latch_bit <= 1'b0;
            end
            // Protection sampled once; later pin changes are harmless
            if (wr.start) begin
                kind_st <= start_st; // see RULE10
                wr_page <= addr[ADDR_W-1:PW];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign so = so_q;
    assign so_oe = selected & ~paused & hold_n_s & tx_on; // see RULE13, see RULE21
    assign standby = ~selected & ~wr.busy; // see RULE12
    assign write_busy = wr.busy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wen_end;
        wen_end && op_q == OP_SET_WEN;
    endsequence
    wel_done_clr_a: assert property (wr.done && !wen_end |=> !write_enable_latch_bit) // see RULE3
        else $error("Latch not cleared after write");
    start_wel_a: assert property (wr.start |-> write_enable_latch_bit && cs_rise) // see RULE2
        else $error("Write started without latch or deselect");
    start_cs_a: assert property (wr.start |=> wr.busy [*3]) // see RULE4
        else $error("Write cycle did not start");
    busy_read_a: assert property (wr.busy && byte_done && state == EEP_CMD
        && rx_byte == OP_READ |=> state == EEP_SKIP) // see RULE5
        else $error("Array read accepted during write");
    hw_prot_a: assert property (cs_rise && state == EEP_SWR && protect_pin_enable_bit
        && !wp_n_s |-> !wr.start) // see RULE7
        else $error("Status write passed hardware protection");
    protect_pin_enable_bit_off_a: assert property (cs_rise && state == EEP_SWR && !protect_pin_enable_bit
        && write_enable_latch_bit && byte_cnt == 2'h1 && seq_clean && !wr.busy
        |-> wr.start) // see RULE9
        else $error("Status write refused with protect enable clear");
    desel_hiz_a: assert property (!selected |-> !so_oe) // see RULE13
        else $error("Output driven while deselected");
    hold_hiz_a: assert property (hold_fall |-> !so_oe) // see RULE21
        else $error("Output driven after hold fall");
    busy_stby_a: assert property ($rose(wr.busy) |-> !standby [*4]) // see RULE12
        else $error("Standby during write cycle");
    prot_drop_a: assert property (wr.start && state == EEP_WR
        |-> !(bp_hi && bp_lo) && !(bp_hi && addr[ADDR_W-1])
        && !(bp_lo && addr[ADDR_W-1] && addr[ADDR_W-2])) // see RULE26
        else $error("Protected block write started");
    wen_set_a: assert property (s_wen_end |=> write_enable_latch_bit) // see RULE25
        else $error("Latch set command ignored");
    pause_hold_a: assert property (paused && selected |=> $stable(shreg)
        && $stable(bit_cnt)) // see RULE19
        else $error("Shift moved while paused");
endmodule
`default_nettype wire

// >>> tb/eep_host.sv
// Host SPI master model that drives the serial EEPROM pins
`timescale 1ns/1ps
`default_nettype none
module eep_host (
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // -----------------------------------------------------------
    // Frame tasks, sck period 160 ns, launched just after clk rise
    // -----------------------------------------------------------
    task automatic sel();
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        #80;
    endtask
    task automatic desel();
        #80;
        cs_n = 1'b1;
        si = ~si;
        #80;
    endtask
    // hold_at 0 to 7 pauses with sck low, 8 to 15 with sck high
    task automatic xfer(input logic [7:0] tx, input int hold_at,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #40;
            if (i == hold_at) begin
                hold_n = 1'b0;
                #80;
                sck = 1'b1;
                si = ~si;
                #80;
                sck = 1'b0;
                #80;
                si = tx[i];
                hold_n = 1'b1;
                #80;
            end
            #40;
            rx[i] = so;
            sck = 1'b1;
            #40;
            // Pause only at the fall; a rise with sck high must not resume
            if (i + 8 == hold_at) begin
                hold_n = 1'b0;
                #40;
                sck = 1'b0;
                #40;
                sck = 1'b1;
                #40;
                hold_n = 1'b1;
                #40;
                sck = 1'b0;
                #40;
                hold_n = 1'b0;
                #40;
                hold_n = 1'b1;
            end
            #40;
            sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_spi_eeprom_protect_and_pin_control.sv
// Self-checking bench of the serial EEPROM protection and pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_spi_eeprom_protect_and_pin_control;
    import eep_pkg::*;
    localparam int WCYC = 2000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_oe, standby, write_busy;
    logic watch = 1'b0;
    logic oe_hit = 1'b0;
    logic [31:0] seed = 32'h98f9;
    logic [7:0] rx, d;
    logic [9:0] a;
    int hcnt = 0;
    int err_count = 0;
    int tests_run = 0;
    wire so_w;
    always #4 clk = ~clk;
    // Released output reads back inverted, never as a stale bit
    assign so_w = so_oe ? so : ~so;
    eep_core #(.WRITE_CYCLES(WCYC)) eep_core_i (.clk(clk), .rstn(rstn),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .standby(standby),
        .write_busy(write_busy));
    eep_host eep_host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .so(so_w));
    // Output drive while watched or well into a pause is a leak
    always @(posedge clk) begin
        hcnt <= hold_n ? 0 : hcnt + 1;
        if ((watch || hcnt > 4) && so_oe === 1'b1) oe_hit <= 1'b1;
    end
    // -----------------------------------------------------------
    // Expectation helpers and checks
    // -----------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] st(input logic protect_pin_enable_bit,
                                      input logic [1:0] bp,
                                      input logic write_enable_latch_bit, input logic write_in_progress_bit);
        return {protect_pin_enable_bit, 3'b000, bp, write_enable_latch_bit, write_in_progress_bit};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // -----------------------------------------------------------
    // Serial sequences
    // -----------------------------------------------------------
    task automatic op(input logic [7:0] o);
        eep_host_i.sel();
        eep_host_i.xfer(o, -1, rx);
        eep_host_i.desel();
    endtask
    task automatic rdst(input int h, input logic [7:0] exp);
        eep_host_i.sel();
        eep_host_i.xfer(OP_RD_STATUS, -1, rx);
        eep_host_i.xfer(8'h00, h, rx);
        eep_host_i.desel();
        chk("status", exp, rx);
    endtask
    task automatic acc(input logic [7:0] o, input logic [9:0] ad,
                       input logic [7:0] dv);
        eep_host_i.sel();
        eep_host_i.xfer(o, -1, rx);
        eep_host_i.xfer({6'h00, ad[9:8]}, -1, rx);
        eep_host_i.xfer(ad[7:0], -1, rx);
        eep_host_i.xfer(dv, -1, rx);
        eep_host_i.desel();
    endtask
    task automatic wrst(input logic [7:0] v);
        eep_host_i.sel();
        eep_host_i.xfer(OP_WR_STATUS, -1, rx);
        eep_host_i.xfer(v, -1, rx);
        eep_host_i.desel();
    endtask
    task automatic wait_idle(input logic started);
        int n;
        n = 0;
        chk("busy", {7'h00, started}, {7'h00, write_busy});
        chk("standby", {7'h00, !started}, {7'h00, standby});
        while (write_busy !== 1'b0 && n < WCYC + 100) begin
            @(posedge clk);
            n++;
        end
        chk("idle", 8'h00, {7'h00, write_busy});
    endtask
    initial begin
        #700000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (8) @(posedge clk);
        chk("reset out", 8'h01, {6'h00, so_oe, standby});
        rdst(-1, st(0, 2'b00, 0, 0));
        acc(OP_WRITE, 10'h005, 8'h5a);
        wait_idle(1'b0);
        op(OP_SET_WEN);
        rdst(-1, st(0, 2'b00, 1, 0));
        op(OP_CLR_WEN);
        rdst(-1, st(0, 2'b00, 0, 0));
        eep_host_i.sel();
        eep_host_i.xfer(OP_SET_WEN, -1, rx);
        eep_host_i.xfer(8'h00, -1, rx);
        eep_host_i.desel();
        rdst(-1, st(0, 2'b00, 0, 0));
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            a = seed[9:0];
            d = seed[17:10];
            op(OP_SET_WEN);
            acc(OP_WRITE, a, d);
            chk("busy standby", 8'h02, {6'h00, write_busy, standby});
            rdst(-1, st(0, 2'b00, 1, 1));
            watch = 1'b1;
            acc(OP_READ, a, 8'h00);
            watch = 1'b0;
            chk("busy read drive", 8'h00, {7'h00, oe_hit});
            wait_idle(1'b1);
            rdst(-1, st(0, 2'b00, 0, 0));
            acc(OP_READ, a, 8'h00);
            chk("array data", d, rx);
        end
        op(OP_SET_WEN);
        wrst(8'h84);
        wait_idle(1'b1);
        rdst(-1, st(1, 2'b01, 0, 0));
        @(posedge clk);
        #1;
        wp_n = 1'b0;
        op(OP_SET_WEN);
        wrst(8'h00);
        wait_idle(1'b0);
        rdst(-1, st(1, 2'b01, 1, 0));
        acc(OP_WRITE, 10'h300, 8'h11);
        wait_idle(1'b0);
        acc(OP_WRITE, 10'h2ff, 8'hc3);
        wait_idle(1'b1);
        acc(OP_READ, 10'h2ff, 8'h00);
        chk("unprotected data", 8'hc3, rx);
        @(posedge clk);
        #1;
        wp_n = 1'b1;
        op(OP_SET_WEN);
        wrst(8'h08);
        @(posedge clk);
        #1;
        wp_n = 1'b0;
        wait_idle(1'b1);
        rdst(3, st(0, 2'b10, 0, 0));
        chk("paused drive", 8'h00, {7'h00, oe_hit});
        op(OP_SET_WEN);
        wrst(8'h00);
        wait_idle(1'b1);
        rdst(11, st(0, 2'b00, 0, 0));
        chk("hold drive", 8'h00, {7'h00, oe_hit});
        give_verdict();
    end
endmodule
`default_nettype wire
